// >>> shared/ovr_pkg.sv
package ovr_pkg;

    // register byte offsets on the bus
    localparam logic [7:0] ADDR_THRESH = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_PIN_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h10;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h14;

    // field positions
    localparam int THR_UPPER_LSB = 0;
    localparam int THR_LOWER_LSB = 8;
    localparam int CTRL_PERIOD_LSB = 0;
    localparam int CTRL_MODE_LSB = 4;
    localparam int CTRL_SINGLE_BIT = 12;

    // reset values
    localparam logic [7:0] UPPER_THR_RST = 8'he4;
    localparam logic [7:0] LOWER_THR_RST = 8'h40;
    localparam logic [2:0] PERIOD_RST = 3'h0;
    localparam logic [4:0] MODE_RST = 5'h00;
    localparam logic [3:0] IRQ_ENABLE_RST = 4'h0;

    // link modes that decide embedded status; MODE_CPLX_EXCL carries none
    localparam logic [4:0] MODE_REAL_DEC = 5'h09;
    localparam logic [4:0] MODE_CPLX_FIRST = 5'h0a;
    localparam logic [4:0] MODE_CPLX_LAST = 5'h10;
    localparam logic [4:0] MODE_CPLX_EXCL = 5'h0c;

    // timing counts in sample-clock cycles
    localparam logic [10:0] STRETCH_BASE = 11'h008;
    localparam logic [8:0] WINDOW_BASE = 9'h001;

    // converted sample from the core, two's complement
    typedef struct packed {
        logic valid;
        logic [11:0] code;
    } sample_t;

    // decimated output word; sel is Q or odd-numbered
    typedef struct packed {
        logic valid;
        logic sel;
        logic [15:0] data;
    } dec_word_t;

endpackage

// >>> hdl/ovr_lane.sv
`timescale 1ns/1ps
`default_nettype none

module ovr_lane
    import ovr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire sample_t smp_i,
    input wire logic [7:0] upper_thr_i,
    input wire logic [7:0] lower_thr_i,
    input wire logic [2:0] period_i,
    input wire logic real_mode_i,
    output logic [1:0] hit_o,
    output logic [1:0] pin_o,
    output logic [1:0] embed_o
);

    ////////////////////////////////////////////////////////////////////
    // magnitude and compare
    logic [10:0] mag;
    logic [7:0] top8;
    logic [1:0] hit_now;
    logic [1:0] hit_reg;
    logic [1:0] hit_next;

    // most negative code saturates to the top magnitude
    always_comb begin
        if (smp_i.code == 12'h800) begin
            mag = 11'h7ff; // see RL4
        end else if (smp_i.code[11]) begin
            mag = 11'((~smp_i.code) + 12'h001); // see RL2
        end else begin
            mag = smp_i.code[10:0];
        end
        top8 = mag[10:3]; // see RL3
        hit_now[0] = smp_i.valid && (top8 >= upper_thr_i); // see RL5
        hit_now[1] = smp_i.valid && (top8 >= lower_thr_i); // see RL5
        hit_next = hit_now;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hit_reg <= 2'h0;
        end else begin
            hit_reg <= hit_next; // see RL18
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin stretch per threshold
    logic [10:0] stretch_len;
    logic [10:0] cnt_reg [2];
    logic [10:0] cnt_next [2];
    logic [1:0] pin_reg;
    logic [1:0] pin_next;

    assign stretch_len = STRETCH_BASE << period_i; // see RL9

    for (genvar t = 0; t < 2; t++) begin : g_thr
        // reload on every event, count down otherwise
        always_comb begin
            if (hit_reg[t]) begin
                cnt_next[t] = stretch_len; // see RL17
            end else if (cnt_reg[t] != 11'h000) begin
                cnt_next[t] = cnt_reg[t] - 11'h001;
            end else begin
                cnt_next[t] = 11'h000;
            end
            pin_next[t] = (cnt_next[t] != 11'h000);
        end

        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                cnt_reg[t] <= 11'h000;
                pin_reg[t] <= 1'b0;
            end else begin
                cnt_reg[t] <= cnt_next[t];
                pin_reg[t] <= pin_next[t];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // monitoring window for embedded bits
    logic [8:0] win_len;
    logic [8:0] win_reg;
    logic [8:0] win_next;
    logic [1:0] acc_reg;
    logic [1:0] acc_next;
    logic [1:0] emb_reg;
    logic [1:0] emb_next;
    logic win_end;

    // window of 2^(n+1) samples in real mode, 2^n otherwise
    always_comb begin
        win_len = real_mode_i ? (WINDOW_BASE << ({1'b0, period_i} + 4'h1))
                              : (WINDOW_BASE << period_i); // see RL13
        win_end = (win_reg + 9'h001 >= win_len);
        win_next = win_reg;
        acc_next = acc_reg | hit_reg;
        emb_next = emb_reg;
        if (win_end) begin
            win_next = 9'h000;
            emb_next = acc_reg | hit_reg;
            acc_next = 2'h0;
        end else begin
            win_next = win_reg + 9'h001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            win_reg <= 9'h000;
            acc_reg <= 2'h0;
            emb_reg <= 2'h0;
        end else begin
            win_reg <= win_next;
            acc_reg <= acc_next;
            emb_reg <= emb_next;
        end
    end

    assign hit_o = hit_reg;
    assign pin_o = pin_reg;
    assign embed_o = emb_reg;

    ////////////////////////////////////////////////////////////////////
    // checks
    a_sat_neg_hit: assert property (@(posedge clk_i) disable iff (rst_i)
        smp_i.valid && smp_i.code == 12'h800 |=> hit_reg == 2'h3) // see RL4
        else $error("most negative code did not trip both thresholds");

    a_pin_follows: assert property (@(posedge clk_i) disable iff (rst_i)
        hit_reg[0] |=> pin_reg[0]) // see RL17
        else $error("upper pin not raised after event");

    a_pin_min_len: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(pin_reg[1]) |-> pin_reg[1] [*8]) // see RL9
        else $error("lower pin pulse shorter than eight cycles");

    a_pin_quiet_fall: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(pin_reg[0]) |-> $past(cnt_reg[0]) == 11'h001
            && !$past(hit_reg[0])) // see RL9
        else $error("upper pin fell before its period ran out");

endmodule

`default_nettype wire

// >>> hdl/ovr_detect_top.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RL1: samples taken on rising edge dual mode, both edges single mode; the code samples on the rising edge only and never uses the single-mode bit.
// RL2: samples are two's complement, sign follows which input is higher.
// RL3: 12-bit sample to magnitude; top 8 bits compared with two thresholds.
// RL4: 11-bit magnitude, most negative saturates to 2047; full scale 255.
// RL5: status bit set when top magnitude bits reach or exceed threshold.
// RL6: both channels share the same pair of thresholds.
// RL7: channel A and B each drive two pins; index 0 upper threshold.
// RL8: receiver ORs A and B pins per threshold in single mode.
// RL9: pin pulse lasts 8 times 2^setting cycles after last event.
// RL10: status embedded in samples only in modes with one control bit.
// RL11: complex modes put upper status in I LSB, lower in Q LSB.
// RL12: real mode puts upper status in even LSB, lower in odd LSB.
// RL13: embed window 2^(n+1) samples real, 2^n complex except mode 12.
// RL14: six interleaved cores feed the detector as merged sample streams.
// RL15: foreground calibration stops sampling; host recalibrates on heat.
// RL16: host may set thresholds near 228 and 64 for gain control.
// RL17: each event reloads the pin counter; pin drops after quiet period.
// RL18: pins and embedded bits move on the sample clock, fixed latency.

module ovr_detect_top
    import ovr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire sample_t [1:0] smp_i,
    input wire logic fg_cal_active_i,
    input wire dec_word_t [1:0] dec_i,
    output dec_word_t [1:0] dec_o,
    output logic chan_a_upper_flag_pin_o,
    output logic chan_a_lower_flag_pin_o,
    output logic chan_b_upper_flag_pin_o,
    output logic chan_b_lower_flag_pin_o,
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////
    // configuration registers
    logic [7:0] upper_threshold_level_reg;
    logic [7:0] upper_threshold_level_next;
    logic [7:0] lower_threshold_level_reg;
    logic [7:0] lower_threshold_level_next;
    logic [2:0] flag_period_select_reg;
    logic [2:0] flag_period_select_next;
    logic [4:0] link_mode_select_reg;
    logic [4:0] link_mode_select_next;
    logic single_mode_reg;
    logic single_mode_next;
    logic [3:0] irq_enable_reg;
    logic [3:0] irq_enable_next;
    logic [3:0] irq_status_reg;
    logic [3:0] irq_status_next;
    logic irq_reg;
    logic irq_next;
    logic ack_reg;
    logic ack_next;
    logic [31:0] rdat_reg;
    logic [31:0] rdat_next;

    logic bus_req;
    logic wr_en;
    logic [31:0] wmask;
    logic [31:0] thr_img;
    logic [31:0] ctrl_img;
    logic [31:0] en_img;
    logic [31:0] thr_new;
    logic [31:0] ctrl_new;
    logic [31:0] en_new;
    logic [3:0] clear_bits;
    logic [3:0] event_bits;
    logic [1:0] hit [2];
    logic [1:0] pin [2];
    logic [1:0] embed [2];
    logic real_mode;
    logic embed_on;

    // current register images and byte-lane merge
    always_comb begin
        bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
        wr_en = bus_req && wb_we_i;
        wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                 {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        thr_img = 32'h0;
        thr_img[THR_UPPER_LSB +: 8] = upper_threshold_level_reg;
        thr_img[THR_LOWER_LSB +: 8] = lower_threshold_level_reg;
        ctrl_img = 32'h0;
        ctrl_img[CTRL_PERIOD_LSB +: 3] = flag_period_select_reg;
        ctrl_img[CTRL_MODE_LSB +: 5] = link_mode_select_reg;
        ctrl_img[CTRL_SINGLE_BIT] = single_mode_reg;
        en_img = {28'h0, irq_enable_reg};
        thr_new = (thr_img & ~wmask) | (wb_dat_i & wmask);
        ctrl_new = (ctrl_img & ~wmask) | (wb_dat_i & wmask);
        en_new = (en_img & ~wmask) | (wb_dat_i & wmask);
    end

    // register writes
    always_comb begin
        upper_threshold_level_next = upper_threshold_level_reg;
        lower_threshold_level_next = lower_threshold_level_reg;
        flag_period_select_next = flag_period_select_reg;
        link_mode_select_next = link_mode_select_reg;
        single_mode_next = single_mode_reg;
        irq_enable_next = irq_enable_reg;
        clear_bits = 4'h0;
        if (wr_en) begin
            unique case (wb_adr_i)
                ADDR_THRESH: begin
                    // one pair serves both channels
                    upper_threshold_level_next =
                        thr_new[THR_UPPER_LSB +: 8]; // see RL6
                    lower_threshold_level_next =
                        thr_new[THR_LOWER_LSB +: 8]; // see RL6
                end
                ADDR_CTRL: begin
                    flag_period_select_next = ctrl_new[CTRL_PERIOD_LSB +: 3];
                    link_mode_select_next = ctrl_new[CTRL_MODE_LSB +: 5];
                    single_mode_next = ctrl_new[CTRL_SINGLE_BIT];
                end
                ADDR_IRQ_CLEAR: begin
                    clear_bits = wb_dat_i[3:0] & {4{wb_sel_i[0]}};
                end
                ADDR_IRQ_ENABLE: begin
                    irq_enable_next = en_new[3:0];
                end
                default: begin
                    clear_bits = 4'h0;
                end
            endcase
        end
    end

    // read mux and acknowledge
    always_comb begin
        ack_next = bus_req;
        rdat_next = rdat_reg;
        if (bus_req && !wb_we_i) begin
            unique case (wb_adr_i)
                ADDR_THRESH: rdat_next = thr_img;
                ADDR_CTRL: rdat_next = ctrl_img;
                ADDR_PIN_STATUS: rdat_next = {28'h0, pin[1], pin[0]};
                ADDR_IRQ_STATUS: rdat_next = {28'h0, irq_status_reg};
                ADDR_IRQ_ENABLE: rdat_next = en_img;
                default: rdat_next = 32'h0;
            endcase
        end else if (bus_req) begin
            rdat_next = 32'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            upper_threshold_level_reg <= UPPER_THR_RST;
            lower_threshold_level_reg <= LOWER_THR_RST;
            flag_period_select_reg <= PERIOD_RST;
            link_mode_select_reg <= MODE_RST;
            single_mode_reg <= 1'b0;
            irq_enable_reg <= IRQ_ENABLE_RST;
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0;
        end else begin
            upper_threshold_level_reg <= upper_threshold_level_next;
            lower_threshold_level_reg <= lower_threshold_level_next;
            flag_period_select_reg <= flag_period_select_next;
            link_mode_select_reg <= link_mode_select_next;
            single_mode_reg <= single_mode_next;
            irq_enable_reg <= irq_enable_next;
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // detector lanes, one per channel
    sample_t [1:0] lane_smp;

    // samples from the interleaved cores; dropped while cores calibrate
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            lane_smp[c] = smp_i[c]; // see RL14
            lane_smp[c].valid = smp_i[c].valid && !fg_cal_active_i; // see RL15
        end
    end

    assign real_mode = (link_mode_select_reg == MODE_REAL_DEC);

    for (genvar c = 0; c < 2; c++) begin : g_lane
        // lane 1 carries the channel b stream in every mode; single mode changes nothing here
        ovr_lane u_lane ( // see RL1
            .clk_i(clk_i),
            .rst_i(rst_i),
            .smp_i(lane_smp[c]),
            .upper_thr_i(upper_threshold_level_reg),
            .lower_thr_i(lower_threshold_level_reg),
            .period_i(flag_period_select_reg),
            .real_mode_i(real_mode),
            .hit_o(hit[c]),
            .pin_o(pin[c]),
            .embed_o(embed[c])
        );
    end

    // each channel drives its own pair of pins
    assign chan_a_upper_flag_pin_o = pin[0][0]; // see RL7
    assign chan_a_lower_flag_pin_o = pin[0][1]; // see RL7
    assign chan_b_upper_flag_pin_o = pin[1][0]; // see RL7
    assign chan_b_lower_flag_pin_o = pin[1][1]; // see RL7

    ////////////////////////////////////////////////////////////////////
    // embedding status in decimated words
    dec_word_t [1:0] dec_reg;
    dec_word_t [1:0] dec_next;

    // only modes with one control bit per sample carry status
    always_comb begin
        embed_on = real_mode || ((link_mode_select_reg >= MODE_CPLX_FIRST)
            && (link_mode_select_reg <= MODE_CPLX_LAST)
            && (link_mode_select_reg != MODE_CPLX_EXCL)); // see RL10
        for (int c = 0; c < 2; c++) begin
            dec_next[c] = dec_i[c];
            if (embed_on) begin
                // sel picks Q or odd word, which carries the lower flag
                dec_next[c].data[0] = dec_i[c].sel ? embed[c][1]
                                                   : embed[c][0]; // see RL11
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dec_reg <= '0;
        end else begin
            dec_reg <= dec_next; // see RL12
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt status, enable and line
    always_comb begin
        event_bits = {hit[1], hit[0]};
        // a new event beats a clear in the same cycle
        irq_status_next = (irq_status_reg & ~clear_bits) | event_bits;
        irq_next = |(irq_status_next & irq_enable_next);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_status_reg <= 4'h0;
            irq_reg <= 1'b0;
        end else begin
            irq_status_reg <= irq_status_next;
            irq_reg <= irq_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;
    assign dec_o = dec_reg;
    assign irq_o = irq_reg;

    ////////////////////////////////////////////////////////////////////
    // checks
    sequence s_bus_req;
        wb_cyc_i && wb_stb_i && !ack_reg;
    endsequence

    sequence s_ack_pulse;
        ack_reg ##1 !ack_reg;
    endsequence

    a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        s_bus_req |=> s_ack_pulse)
        else $error("bus answer not a single cycle after request");

    a_thr_write: assert property (@(posedge clk_i) disable iff (rst_i)
        s_bus_req and (wb_we_i && wb_adr_i == ADDR_THRESH
            && wb_sel_i == 4'hf)
        |=> upper_threshold_level_reg == $past(wb_dat_i[7:0])) // see RL6
        else $error("upper threshold write lost");

    a_set_beats_clr: assert property (@(posedge clk_i) disable iff (rst_i)
        hit[0][0] |=> irq_status_reg[0])
        else $error("event lost against a clear");

    a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_reg == |(irq_status_reg & irq_enable_reg))
        else $error("interrupt line disagrees with status and enable");

    a_embed_lsb: assert property (@(posedge clk_i) disable iff (rst_i)
        embed_on && dec_i[0].sel |=> dec_reg[0].data[0] == $past(embed[0][1])
            && dec_reg[0].data[15:1] == $past(dec_i[0].data[15:1])) // see RL11
        else $error("lower status not embedded in Q word");

    a_no_embed: assert property (@(posedge clk_i) disable iff (rst_i)
        !embed_on |=> dec_reg == $past(dec_i)) // see RL10
        else $error("word altered outside embedding modes");

    a_cal_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        fg_cal_active_i |=> hit[0] == 2'h0 && hit[1] == 2'h0) // see RL15
        else $error("detection active during calibration");

    a_pin_latency: assert property (@(posedge clk_i) disable iff (rst_i)
        smp_i[1].valid && !fg_cal_active_i && smp_i[1].code[11:3] == 9'h0ff
        |-> ##2 chan_b_upper_flag_pin_o) // see RL18
        else $error("channel b pin not raised two cycles after full scale");

endmodule

`default_nettype wire

// >>> sim/gain_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

// downstream gain manager watching the four flag pins
module gain_ctrl_model #(
    parameter int QUIET_LEN = 64
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] pins_i,
    output logic upper_any_o,
    output logic lower_any_o,
    output logic raise_gain_o
);
    int quiet_reg;

    // either channel flags the threshold
    assign upper_any_o = pins_i[0] | pins_i[2];
    assign lower_any_o = pins_i[1] | pins_i[3];

    // long silence on the lower flag asks for more gain
    always_ff @(posedge clk_i) begin
        if (rst_i || lower_any_o) begin
            quiet_reg <= 0;
        end else if (quiet_reg < QUIET_LEN) begin
            quiet_reg <= quiet_reg + 1;
        end
    end
    assign raise_gain_o = (quiet_reg == QUIET_LEN);
endmodule

`default_nettype wire

// >>> sim/adc_overrange_detector_bench.sv
`timescale 1ns/1ps
`default_nettype none

module adc_overrange_detector_bench;
    import ovr_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [3:0] sel = 4'hf;
    logic [3:0] lanes = 4'hf;
    logic [31:0] rdat;
    logic ack;
    logic fg_cal = 1'b0;
    logic b_hit = 1'b0;
    logic [31:0] r;
    sample_t [1:0] smp = '0;
    dec_word_t [1:0] dec_in = '0;
    dec_word_t [1:0] dec_out;
    logic [3:0] pins;
    logic irq, up_any, low_any, raise;
    int errors = 0;
    int samples_checked = 0;
    int seed = 32'hb753;
    int run_len = 0;
    logic [31:0] rd_q[$];
    int len_q[$];
    logic [31:0] dec_q[$];
    logic [7:0] thr_tb [6] = '{8'hff, 8'hff, 8'hff, 8'hfe, 8'hfe, 8'hfe};
    logic [11:0] code_tb [6] = '{12'h7ff, 12'h800, 12'h7f0, 12'h7f0,
        12'h810, 12'h7e8};
    logic hit_tb [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

    initial begin
        forever #4 clk_i = ~clk_i;
    end

    ovr_detect_top uut (
        .clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack),
        .smp_i(smp), .fg_cal_active_i(fg_cal),
        .dec_i(dec_in), .dec_o(dec_out),
        .chan_a_upper_flag_pin_o(pins[0]),
        .chan_a_lower_flag_pin_o(pins[1]),
        .chan_b_upper_flag_pin_o(pins[2]),
        .chan_b_lower_flag_pin_o(pins[3]),
        .irq_o(irq)
    );

    gain_ctrl_model #(.QUIET_LEN(64)) partner (
        .clk_i(clk_i), .rst_i(rst_i), .pins_i(pins),
        .upper_any_o(up_any), .lower_any_o(low_any),
        .raise_gain_o(raise)
    );

    ////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk_word(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_len(input string what, input int exp, input int got);
        samples_checked++;
        if (got != exp) begin
            errors++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // one classic cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we} <= {2'b11, w};
        adr <= a;
        dat <= d;
        sel <= lanes;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            conclude();
        end
        {cyc, stb, we} <= 3'b000;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        rd_q.push_back(exp);
        wb(1'b0, a, 32'h0);
    endtask

    // one sample of the given code held for n edges on channel a
    task automatic hit(input logic [11:0] code, input int n);
        smp[0] <= '{1'b1, code};
        repeat (n) @(posedge clk_i);
        smp[0] <= '{1'b0, 12'h000};
    endtask

    // wait until every expected pulse has come and gone
    task automatic settle();
        int n;
        n = 0;
        while ((len_q.size() > 0 || run_len > 0) && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 3000) begin
            errors++;
            conclude();
        end
        repeat (12) @(posedge clk_i);
    endtask

    ////////////////////////////////////////////////////////////////////
    // channel b: small random codes, or one full-scale code on request
    always @(posedge clk_i) begin
        r = $random(seed);
        smp[1] <= b_hit ? '{1'b1, 12'h7ff} : '{1'b1, {{6{r[5]}}, r[5:0]}};
    end

    // watcher: read data, pulse lengths, embedded words
    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0) begin
            chk_word("read", rd_q.size() ? rd_q.pop_front() : 32'hdeadbeef,
                rdat);
        end
        if (up_any === 1'b1) begin
            run_len++;
        end else if (run_len > 0) begin
            chk_len("pulse", len_q.size() ? len_q.pop_front() : 0,
                run_len);
            run_len = 0;
        end
        if (dec_out[0].valid === 1'b1) begin
            chk_word("embed", dec_q.size() ? dec_q.pop_front() : 32'h0,
                {dec_out[1].data, dec_out[0].data});
        end
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        // reset values and an unmapped place
        rd(ADDR_THRESH, {16'h0, LOWER_THR_RST, UPPER_THR_RST});
        rd(ADDR_CTRL, 32'h0);
        rd(ADDR_IRQ_ENABLE, 32'h0);
        rd(ADDR_IRQ_CLEAR, 32'h0);
        rd(8'h3c, 32'h0);
        // byte lanes: only the lower-threshold byte lands
        lanes = 4'h2;
        wb(1'b1, ADDR_THRESH, 32'h0000_5566);
        lanes = 4'hf;
        rd(ADDR_THRESH, {16'h0, 8'h55, UPPER_THR_RST});
        // magnitude folding and threshold edges
        foreach (thr_tb[i]) begin
            wb(1'b1, ADDR_THRESH, {16'h0, 8'h40, thr_tb[i]});
            if (hit_tb[i]) len_q.push_back(8);
            hit(code_tb[i], 1);
            settle();
        end
        // every period setting
        for (int p = 0; p < 8; p++) begin
            wb(1'b1, ADDR_CTRL, 32'(p));
            len_q.push_back(8 << p);
            hit(12'h7ff, 1);
            settle();
        end
        wb(1'b1, ADDR_CTRL, 32'h0);
        // second event five edges later stretches the pulse
        len_q.push_back(13);
        hit(12'h7ff, 1);
        repeat (4) @(posedge clk_i);
        hit(12'h7ff, 1);
        settle();
        // calibration downtime ignores samples
        fg_cal <= 1'b1;
        hit(12'h7ff, 2);
        fg_cal <= 1'b0;
        settle();
        // channel b alone in single mode, same thresholds
        wb(1'b1, ADDR_CTRL, 32'h1000);
        len_q.push_back(8);
        b_hit <= 1'b1;
        @(posedge clk_i);
        b_hit <= 1'b0;
        settle();
        // interrupt: clear, enable, raise, check pins, clear again
        wb(1'b1, ADDR_IRQ_CLEAR, 32'hf);
        rd(ADDR_IRQ_STATUS, 32'h0);
        wb(1'b1, ADDR_IRQ_ENABLE, 32'h1);
        len_q.push_back(8);
        hit(12'h7ff, 1);
        repeat (2) @(posedge clk_i);
        chk_word("pins", 32'h3, {28'h0, pins});
        settle();
        rd(ADDR_IRQ_STATUS, 32'h3);
        chk_word("irq", 32'h1, {31'h0, irq});
        rd(ADDR_PIN_STATUS, 32'h0);
        wb(1'b1, ADDR_IRQ_CLEAR, 32'h1);
        rd(ADDR_IRQ_STATUS, 32'h2);
        chk_word("irq", 32'h0, {31'h0, irq});
        // embedding across link modes, both word kinds
        for (int m = 8; m < 18; m++) begin
            wb(1'b1, ADDR_CTRL, {23'h0, 5'(m), 4'h0});
            len_q.push_back(19);
            smp[0] <= '{1'b1, 12'h7ff};
            repeat (6) @(posedge clk_i);
            for (int s = 0; s < 2; s++) begin
                dec_in <= '{'{1'b1, 1'(s), 16'h1235},
                    '{1'b1, 1'(s), 16'h1234}};
                dec_q.push_back((m inside {[9:11], [13:16]})
                    ? 32'h1234_1235 : 32'h1235_1234);
                @(posedge clk_i);
            end
            dec_in <= '0;
            repeat (4) @(posedge clk_i);
            smp[0] <= '{1'b0, 12'h000};
            settle();
        end
        // long quiet on the lower flag asks for more gain
        repeat (70) @(posedge clk_i);
        chk_word("raise", 32'h1, {31'h0, raise});
        conclude();
    end
endmodule

`default_nettype wire
